// File: include/but_pkg.sv
// Purpose: constants for the basic up-count timer
// Assumes: single 200 MHz core clock
// Notes:   register map is for reference; block uses plain ports
package but_pkg;
  localparam int        BUT_WIDTH      = 16;
  localparam logic [15:0] BUT_RELOAD_RST = 16'hffff;
  localparam logic [15:0] BUT_PSC_RST    = 16'h0000;
  localparam logic [15:0] BUT_CNT_RST    = 16'h0000;
  // Register offsets of the original map
  localparam logic [7:0] BUT_OFS_CTRL1  = 8'h00;
  localparam logic [7:0] BUT_OFS_CTRL2  = 8'h04;
  localparam logic [7:0] BUT_OFS_IEN    = 8'h0c;
  localparam logic [7:0] BUT_OFS_STATUS = 8'h10;
  localparam logic [7:0] BUT_OFS_EVGEN  = 8'h14;
  localparam logic [7:0] BUT_OFS_COUNT  = 8'h24;
  localparam logic [7:0] BUT_OFS_PSC    = 8'h28;
  localparam logic [7:0] BUT_OFS_RELOAD = 8'h2c;
  typedef enum logic [2:0] {
    BUT_TRG_FORCE  = 3'b000,
    BUT_TRG_ENABLE = 3'b001,
    BUT_TRG_UPDATE = 3'b010
  } but_trg_sel_t;
endpackage

// File: rtl/but_basic_upcount_timer.sv
// Purpose: basic 16-bit timebase timer with prescaler and auto-reload
// Assumes: software writes arrive as one-cycle write strobes
// Notes:   one instance per timer, nothing shared between instances
//
// How it works
// - Count 0 to reload value, wrap, overflow
// - Prescaler divides clock by 1 to 65536
// - New prescale takes effect at next update
// - Reload accesses hit preload, not shadow
// - Shadow loads on write or at update
// - Overflow gives update unless updates disabled
// - Counter advances only on gated prescaled tick
// - Counter-run signal follows enable one cycle later
// - Force-update bit generates an update event
// - Update disable blocks events, buffered shadows hold
// - Forced update still clears counters, ratio kept
// - Source select hides forced update from flag
// - Update loads prescaler, shadow, sets flag
// - Interrupt and DMA requests on any update that sets the flag
// - Counter, reload, prescale writable any time
// - Internal clock feeds prescaler once enabled
// - Only software sets enable bit; force bit also set by slave force
// - Debug halt freezes counter if selected
// - Trigger output paces the converter
// - Instance is self-contained
// - Preload enable: 0 direct, 1 buffered
// - One-shot clears enable at update
// - No counting while active reload is zero
// - Trigger select: force, run, update
`timescale 1ns/1ps

module but_basic_upcount_timer
  import but_pkg::*;
#(
  parameter int WIDTH = BUT_WIDTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Control bits
  input  wire logic             countEnableWr,
  input  wire logic             countEnableIn,
  output logic                  countEnableBit,
  input  wire logic             reloadPreloadEnable,
  input  wire logic             oneShotMode,
  input  wire logic             updateSourceSelect,
  input  wire logic             updateDisable,
  input  wire logic [2:0]       triggerOutputSelect,
  input  wire logic             updateIrqEnable,
  input  wire logic             updateDmaEnable,
  // Event generation
  input  wire logic             forceUpdateWr,
  input  wire logic             slaveForceUpdate,
  output logic                  forceUpdate,
  // Status
  input  wire logic             updateFlagClr,
  output logic                  updateFlag,
  // Counter, prescale and reload access
  input  wire logic             countWr,
  input  wire logic [WIDTH-1:0] countWrData,
  output logic      [WIDTH-1:0] countValue,
  input  wire logic             prescaleWr,
  input  wire logic [WIDTH-1:0] prescaleWrData,
  output logic      [WIDTH-1:0] prescaleSetting,
  input  wire logic             reloadWr,
  input  wire logic [WIDTH-1:0] reloadWrData,
  output logic      [WIDTH-1:0] reloadValue,
  // Debug
  input  wire logic             debugHalt,
  input  wire logic             debugFreezeSelect,
  // Outputs
  output logic                  counterRunSignal,
  output logic                  updateEvent,
  output logic                  updateIrq,
  output logic                  updateDmaReq,
  output logic                  triggerOutput
);

  // all state local
  // Nothing here is shared, so instances never interact
  logic [WIDTH-1:0] prescaleActive;
  logic [WIDTH-1:0] prescaleCount;
  logic [WIDTH-1:0] reloadShadow;
  logic             prescaledTick;
  logic             overflow;
  logic             forceReq;
  logic             updateFire;
  logic             flagSet;
  logic             halted;
  logic             run;
  logic [WIDTH-1:0] next_prescaleCount;
  logic [WIDTH-1:0] next_prescaleActive;
  logic [WIDTH-1:0] next_prescaleSetting;
  logic [WIDTH-1:0] next_countValue;
  logic [WIDTH-1:0] next_reloadValue;
  logic [WIDTH-1:0] next_reloadShadow;
  logic             next_countEnableBit;
  logic             next_updateFlag;
  logic             next_triggerOutput;

  // Width-exact increment: the carry out of the top bit is dropped on
  // purpose, which is what makes a counter wrap through zero
  function automatic logic [WIDTH-1:0] but_incr(
    input logic [WIDTH-1:0] val
  );
    logic [WIDTH:0] sum;
    sum = {1'b0, val} + {{WIDTH{1'b0}}, 1'b1};
    return sum[WIDTH-1:0];
  endfunction

  // A counter has reached its limit and restarts on this edge
  function automatic logic but_at_limit(
    input logic [WIDTH-1:0] val,
    input logic [WIDTH-1:0] lim
  );
    return val == lim;
  endfunction

  assign halted = debugHalt && debugFreezeSelect;
  // Run also needs the live enable bit, so a one-shot stop takes
  // effect at once instead of letting one more tick through
  assign run    = counterRunSignal && countEnableBit && !halted;

  assign forceReq = forceUpdateWr || slaveForceUpdate;

  assign prescaledTick = run && but_at_limit(prescaleCount, prescaleActive);

  assign overflow = prescaledTick && (reloadShadow != '0)
                    && but_at_limit(countValue, reloadShadow);

  assign updateFire = !updateDisable && (overflow || forceReq);

  // forced update hidden when source select set
  assign flagSet = !updateDisable
                   && (overflow || (forceReq && !updateSourceSelect));

  // run signal one cycle after enable
  // internal clock feeds prescaler once enabled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      counterRunSignal <= 1'b0;
    end else begin
      counterRunSignal <= countEnableBit;
    end
  end

  // one-shot stops at update
  // Hardware stop wins over a software write in the same cycle
  always_comb begin
    next_countEnableBit = countEnableBit;
    if (oneShotMode && updateFire) begin
      next_countEnableBit = 1'b0;
    end else if (countEnableWr) begin
      next_countEnableBit = countEnableIn;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      countEnableBit <= 1'b0;
    end else begin
      countEnableBit <= next_countEnableBit;
    end
  end

  // A request held for two cycles reads back high for both
  // force bit self-clears
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      forceUpdate <= 1'b0;
    end else begin
      forceUpdate <= forceReq;
    end
  end

  always_comb begin
    next_prescaleCount = prescaleCount;
    if (forceReq || prescaledTick) begin
      next_prescaleCount = '0;
    end else if (run) begin
      next_prescaleCount = but_incr(prescaleCount);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prescaleCount <= BUT_CNT_RST;
    end else begin
      prescaleCount <= next_prescaleCount;
    end
  end

  // forced update restarts counter
  // A count written above the reload value runs on and wraps through zero
  always_comb begin
    next_countValue = countValue;
    if (forceReq || overflow) begin
      next_countValue = '0;
    end else if (countWr) begin
      next_countValue = countWrData;
    end else if (prescaledTick && reloadShadow != '0) begin
      next_countValue = but_incr(countValue);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      countValue <= BUT_CNT_RST;
    end else begin
      countValue <= next_countValue;
    end
  end

  always_comb begin
    next_prescaleSetting = prescaleSetting;
    if (prescaleWr) begin
      next_prescaleSetting = prescaleWrData;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prescaleSetting <= BUT_PSC_RST;
    end else begin
      prescaleSetting <= next_prescaleSetting;
    end
  end

  always_comb begin
    next_prescaleActive = prescaleActive;
    if (updateFire) begin
      next_prescaleActive = prescaleSetting;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prescaleActive <= BUT_PSC_RST;
    end else begin
      prescaleActive <= next_prescaleActive;
    end
  end

  always_comb begin
    next_reloadValue = reloadValue;
    if (reloadWr) begin
      next_reloadValue = reloadWrData;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reloadValue <= BUT_RELOAD_RST;
    end else begin
      reloadValue <= next_reloadValue;
    end
  end

  // shadow load on write or update
  // direct when preload enable is 0
  always_comb begin
    next_reloadShadow = reloadShadow;
    if (!reloadPreloadEnable && reloadWr) begin
      next_reloadShadow = reloadWrData;
    end else if (!reloadPreloadEnable) begin
      next_reloadShadow = reloadValue;
    end else if (updateFire) begin
      next_reloadShadow = reloadValue;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reloadShadow <= BUT_RELOAD_RST;
    end else begin
      reloadShadow <= next_reloadShadow;
    end
  end

  always_comb begin
    next_updateFlag = updateFlag;
    if (flagSet) begin
      next_updateFlag = 1'b1;
    end else if (updateFlagClr) begin
      next_updateFlag = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      updateFlag <= 1'b0;
    end else begin
      updateFlag <= next_updateFlag;
    end
  end

  // Event strobe registered so the data output comes from a flop
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      updateEvent <= 1'b0;
    end else begin
      updateEvent <= updateFire;
    end
  end

  // Levels, not pulses: they stand until the flag is cleared
  // request levels follow the flag
  assign updateIrq    = updateFlag && updateIrqEnable;
  assign updateDmaReq = updateFlag && updateDmaEnable;

  always_comb begin
    unique case (triggerOutputSelect)
      BUT_TRG_FORCE:  next_triggerOutput = forceReq;
      BUT_TRG_ENABLE: next_triggerOutput = counterRunSignal;
      BUT_TRG_UPDATE: next_triggerOutput = updateFire;
      // Reserved codes keep the output low
      default:        next_triggerOutput = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      triggerOutput <= 1'b0;
    end else begin
      triggerOutput <= next_triggerOutput;
    end
  end

endmodule

// File: tb/but_timer_sva.sv
// Purpose: port checks for the up-count timer
// Assumes: one clock, reset async active high
// Notes:   bound below to every timer instance
`timescale 1ns/1ps
module but_timer_sva #(
  parameter int WIDTH = 16
) (
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             countEnableBit,
  input wire logic             counterRunSignal,
  input wire logic             updateFlag,
  input wire logic             updateIrqEnable,
  input wire logic             updateIrq,
  input wire logic             updateDmaEnable,
  input wire logic             updateDmaReq,
  input wire logic             updateEvent,
  input wire logic             updateDisable,
  input wire logic             forceUpdateWr,
  input wire logic             slaveForceUpdate,
  input wire logic             forceUpdate,
  input wire logic             countWr,
  input wire logic [WIDTH-1:0] countValue,
  input wire logic [2:0]       triggerOutputSelect,
  input wire logic             triggerOutput
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_run_follows: assert property (
    $rose(countEnableBit) |=> counterRunSignal) else $error("run late");
  a_req_levels: assert property (
    {updateIrq, updateDmaReq} == {updateFlag && updateIrqEnable,
    updateFlag && updateDmaEnable}) else $error("request level");
  a_flag_event: assert property (
    $rose(updateFlag) |-> updateEvent) else $error("no event");
  a_update_disable_quiet: assert property (
    $past(updateDisable) |-> !updateEvent) else $error("event in disable");
  a_force_zero: assert property (
    $past(forceUpdateWr) || $past(slaveForceUpdate) |-> countValue == '0)
    else $error("force kept count");
  a_force_clears: assert property (
    forceUpdate |=> !forceUpdate) else $error("force bit stuck");
  // Run lags enable by a cycle, so both must be low before the hold
  a_idle_hold: assert property (
    !$past(countEnableBit) && !$past(counterRunSignal) && !$past(countWr)
    && !$past(forceUpdateWr) && !$past(slaveForceUpdate)
    |-> $stable(countValue)) else $error("count moved idle");
  a_trig_update: assert property (
    $past(triggerOutputSelect) == 3'b010 |-> triggerOutput == updateEvent)
    else $error("trigger not update");
  a_trig_run: assert property (
    $past(triggerOutputSelect) == 3'b001
    |-> triggerOutput == $past(counterRunSignal))
    else $error("trigger not run");
endmodule
bind but_basic_upcount_timer but_timer_sva #(.WIDTH(WIDTH)) u_sva (
  .core_clk, .rst, .countEnableBit, .counterRunSignal, .updateFlag,
  .updateIrqEnable, .updateIrq, .updateDmaEnable, .updateDmaReq,
  .updateEvent, .updateDisable, .forceUpdateWr, .slaveForceUpdate,
  .forceUpdate, .countWr, .countValue, .triggerOutputSelect, .triggerOutput);

// File: tb/but_basic_upcount_timer_test.sv
// Purpose: directed bench for the up-count timer
// Assumes: inputs move 1 ns after the rising edge
// Notes:   periods are counted in core clock cycles
`timescale 1ns/1ps
module but_basic_upcount_timer_test;
  logic        core_clk, rst, countEnableWr, countEnableIn, oneShotMode;
  logic        reloadPreloadEnable, updateSourceSelect, updateDisable;
  logic        updateIrqEnable, updateDmaEnable, forceUpdateWr;
  logic        slaveForceUpdate, updateFlagClr, countWr, prescaleWr;
  logic        reloadWr, debugHalt, debugFreezeSelect, countEnableBit;
  logic        forceUpdate, updateFlag, counterRunSignal, updateEvent;
  logic        updateIrq, updateDmaReq, triggerOutput;
  logic [2:0]  triggerOutputSelect;
  logic [15:0] countWrData, countValue, prescaleWrData, prescaleSetting;
  logic [15:0] reloadWrData, reloadValue, v;
  int          miscompares, samplesChecked, n;
  but_basic_upcount_timer DUT (.core_clk, .rst, .countEnableWr,
    .countEnableIn, .countEnableBit, .reloadPreloadEnable, .oneShotMode,
    .updateSourceSelect, .updateDisable, .triggerOutputSelect,
    .updateIrqEnable, .updateDmaEnable, .forceUpdateWr, .slaveForceUpdate,
    .forceUpdate, .updateFlagClr, .updateFlag, .countWr, .countWrData,
    .countValue, .prescaleWr, .prescaleWrData, .prescaleSetting, .reloadWr,
    .reloadWrData, .reloadValue, .debugHalt, .debugFreezeSelect,
    .counterRunSignal, .updateEvent, .updateIrq, .updateDmaReq,
    .triggerOutput);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic tick(input int k = 1);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // First edge clears the flag, so n is a whole overflow period
  task automatic period(output int k);
    updateFlagClr = 1'b1;
    k = 0;
    do begin
      tick();
      updateFlagClr = 1'b0;
      k++;
    end while (updateFlag !== 1'b1 && k < 2000);
    if (k >= 2000) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic en(input logic e);
    countEnableIn = e;
    pulse(countEnableWr);
  endtask
  task automatic t_basic;
    chk(reloadValue, 16'hffff);
    chk(countValue, 16'h0000);
    reloadWrData = 16'h0002;
    pulse(reloadWr);
    en(1'b1);
    chk(counterRunSignal, 1'b0);
    tick();
    chk(counterRunSignal, 1'b1);
    period(n);
    period(n);
    chk(n, 3);
    chk(countValue, 16'h0000);
    chk(updateIrq & updateDmaReq, 1'b1);
    chk(updateEvent, 1'b1);
    tick();
    chk(updateEvent, 1'b0);
  endtask
  task automatic t_prescale;
    period(n);
    prescaleWrData = 16'h0001;
    pulse(prescaleWr);
    period(n);
    chk(n, 2);
    period(n);
    chk(n, 6);
    chk(prescaleSetting, 16'h0001);
  endtask
  task automatic t_force;
    en(1'b0);
    tick(2);
    countWrData = 16'h0005;
    pulse(countWr);
    chk(countValue, 16'h0005);
    prescaleWrData = 16'h0000;
    pulse(prescaleWr);
    pulse(updateFlagClr);
    updateSourceSelect = 1'b1;
    pulse(forceUpdateWr);
    chk(forceUpdate, 1'b1);
    chk(countValue, 16'h0000);
    chk(updateFlag, 1'b0);
    tick(2);
    chk(forceUpdate, 1'b0);
    updateSourceSelect = 1'b0;
    pulse(slaveForceUpdate);
    chk(updateFlag, 1'b1);
    en(1'b1);
    period(n);
    period(n);
    chk(n, 3);
  endtask
  task automatic t_update_disable;
    reloadPreloadEnable = 1'b1;
    updateDisable = 1'b1;
    reloadWrData = 16'h0005;
    pulse(reloadWr);
    chk(reloadValue, 16'h0005);
    pulse(updateFlagClr);
    tick(9);
    chk(updateFlag, 1'b0);
    chk(countValue <= 16'h0002, 1'b1);
    pulse(forceUpdateWr);
    chk(countValue, 16'h0000);
    updateDisable = 1'b0;
    period(n);
    chk(n, 3);
    period(n);
    chk(n, 6);
    reloadPreloadEnable = 1'b0;
    reloadWrData = 16'h0002;
    pulse(reloadWr);
  endtask
  task automatic t_oneshot;
    oneShotMode = 1'b1;
    period(n);
    chk(countEnableBit, 1'b0);
    tick(3);
    chk(countValue, 16'h0000);
    oneShotMode = 1'b0;
  endtask
  task automatic t_zero;
    reloadWrData = 16'h0000;
    pulse(reloadWr);
    pulse(updateFlagClr);
    en(1'b1);
    tick(6);
    chk(countValue, 16'h0000);
    chk(updateFlag, 1'b0);
    reloadWrData = 16'hffff;
    pulse(reloadWr);
  endtask
  task automatic t_debug;
    debugHalt = 1'b1;
    debugFreezeSelect = 1'b1;
    tick(2);
    v = countValue;
    tick(5);
    chk(countValue, v);
    debugFreezeSelect = 1'b0;
    tick(3);
    chk(countValue > v, 1'b1);
    debugHalt = 1'b0;
  endtask
  task automatic t_trig;
    triggerOutputSelect = 3'b001;
    tick(3);
    chk(triggerOutput, 1'b1);
    triggerOutputSelect = 3'b000;
    tick(3);
    chk(triggerOutput, 1'b0);
    forceUpdateWr = 1'b1;
    v = '0;
    repeat (3) begin
      tick();
      forceUpdateWr = 1'b0;
      v[0] = v[0] | triggerOutput;
    end
    chk(v[0], 1'b1);
    triggerOutputSelect = 3'b010;
    reloadWrData = 16'h0002;
    pulse(reloadWr);
    // Count is already past the new limit; restart it so it cannot wrap
    pulse(forceUpdateWr);
    period(n);
    chk(n, 3);
    chk(triggerOutput, 1'b1);
    updateIrqEnable = 1'b0;
    tick();
    chk(triggerOutput, 1'b0);
    chk(updateIrq, 1'b0);
    chk(updateDmaReq, 1'b1);
  endtask
  initial begin
    {countEnableWr, countEnableIn, oneShotMode, reloadPreloadEnable,
      updateSourceSelect, updateDisable, forceUpdateWr, slaveForceUpdate,
      updateFlagClr, countWr, prescaleWr, reloadWr, debugHalt,
      debugFreezeSelect, triggerOutputSelect, countWrData, prescaleWrData,
      reloadWrData} = '0;
    {updateIrqEnable, updateDmaEnable} = 2'b11;
    rst = 1'b1;
    tick(8);
    rst = 1'b0;
    t_basic();
    t_prescale();
    t_force();
    t_update_disable();
    t_oneshot();
    t_zero();
    t_debug();
    t_trig();
    give_verdict();
  end
endmodule
